// ### hw/evt_timer_pkg.sv
// Constants for the event capture timer and divider block
`default_nettype none
package evt_timer_pkg;
   // Register byte offsets
   localparam logic [4:0] OFS_CONTROL  = 5'h00;
   localparam logic [4:0] OFS_PRELOAD  = 5'h04;
   localparam logic [4:0] OFS_COUNT    = 5'h08;
   localparam logic [4:0] OFS_INTCTL   = 5'h0c;
   localparam logic [4:0] OFS_OUTCTL   = 5'h10;
   // Control register fields
   localparam int MODE_HI     = 7;
   localparam int MODE_LO     = 6;
   localparam int EN_BIT      = 4;
   localparam int EDGE_BIT    = 3;
   localparam int RATE_HI     = 2;
   localparam int RATE_LO     = 0;
   localparam logic [7:0] CONTROL_RST  = 8'h08;
   localparam logic [7:0] CONTROL_MASK = 8'hdf;
   // Interrupt control fields
   localparam int IEN_BIT     = 0;
   localparam int IFLAG_BIT   = 1;
   // Output control fields
   localparam int SRC_BIT     = 0;
   localparam int DATA0_BIT   = 1;
   localparam int DATA1_BIT   = 2;
   localparam int PULL_BIT    = 3;
   // Counter limits
   localparam logic [7:0] FULL_COUNT   = 8'hff;
   localparam int PRESCALE_W  = 7;
   localparam int NUM_DIV_OUT = 2;
   // Operating modes
   typedef enum logic [1:0] {
      MODE_NONE    = 2'h0,
      MODE_EVENT   = 2'h1,
      MODE_TIMER   = 2'h2,
      MODE_CAPTURE = 2'h3
   } mode_type;
   // Capture sequencer
   typedef enum logic {CAP_WAIT, CAP_RUN} cap_state_type;
endpackage : evt_timer_pkg
`default_nettype wire

// ### hw/event_capture_timer_divider.sv
// Eight-bit event counter, pulse width capture timer and overflow frequency divider
`timescale 1ns/10ps
`default_nettype none
module event_capture_timer_divider (
   input  wire logic                                   i_clk,
   input  wire logic                                   i_nrst,
   input  wire logic [4:0]                             i_address,
   input  wire logic                                   i_read,
   input  wire logic                                   i_write,
   input  wire logic [31:0]                            i_writedata,
   input  wire logic [3:0]                             i_byteenable,
   output var  logic [31:0]                            o_readdata,
   output var  logic                                   o_waitrequest,
   input  wire logic                                   i_timer_input_pin,
   input  wire logic                                   i_other_timer_overflow,
   input  wire logic                                   i_sleep,
   output var  logic                                   o_timer_irq,
   output var  logic                                   o_wakeup,
   output var  logic [evt_timer_pkg::NUM_DIV_OUT-1:0]  o_programmable_divider_out,
   output var  logic                                   o_pin_pullup_en
);
   import evt_timer_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]            control_r, control_nxt;
   logic [7:0]            preload_r, preload_nxt;
   logic [7:0]            count_r, count_nxt;
   logic                  irq_en_r, irq_en_nxt;
   logic                  irq_flag_r, irq_flag_nxt;
   logic                  src_sel_r, src_sel_nxt;
   logic [1:0]            data_bits_r, data_bits_nxt;
   logic                  pull_r, pull_nxt;
   logic                  div_state_r, div_state_nxt;
   logic [PRESCALE_W-1:0] prescale_r, prescale_nxt;
   cap_state_type         cap_r, cap_nxt;
   logic                  pin_s1_r, pin_s2_r, pin_prev_r;
   logic                  wait_r, wait_nxt;
   logic [31:0]           rdata_r, rdata_nxt;
   logic                  irq_out_r, irq_out_nxt;
   logic                  wake_r, wake_nxt;
   logic [NUM_DIV_OUT-1:0] div_out_r, div_out_nxt;

   // Decoded helpers
   mode_type              mode;
   logic                  en;
   logic                  edge_sel;
   logic [2:0]            rate;
   logic                  pin_rise;
   logic                  pin_fall;
   logic                  tick;
   logic                  inc;
   logic                  ovf;
   logic                  wr_ok;
   logic                  ctrl_wr;
   logic                  pre_wr;
   logic                  hw_clear;
   logic [PRESCALE_W-1:0] rate_mask;

   assign mode     = mode_type'(control_r[MODE_HI:MODE_LO]);
   assign en       = control_r[EN_BIT];
   assign edge_sel = control_r[EDGE_BIT];
   assign rate     = control_r[RATE_HI:RATE_LO];

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and edge detect
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pin_s1_r   <= 1'b0;
         pin_s2_r   <= 1'b0;
         pin_prev_r <= 1'b0;
      end else begin
         pin_s1_r   <= i_timer_input_pin;
         pin_s2_r   <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
      end
   end

   // Edges only, never levels
   assign pin_rise = pin_s2_r & ~pin_prev_r;
   assign pin_fall = ~pin_s2_r & pin_prev_r;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake
   assign wr_ok   = i_write & ~wait_r & i_byteenable[0];
   assign ctrl_wr = wr_ok & (i_address == OFS_CONTROL);
   assign pre_wr  = wr_ok & (i_address == OFS_PRELOAD);

   // One wait cycle, then the access completes
   always_comb begin
      wait_nxt  = 1'b1;
      rdata_nxt = rdata_r;
      if ((i_read | i_write) & wait_r) begin
         wait_nxt  = 1'b0;
         rdata_nxt = 32'h0;
         case (i_address)
            OFS_CONTROL: rdata_nxt[7:0] = control_r & CONTROL_MASK;
            OFS_PRELOAD: rdata_nxt[7:0] = preload_r;
            OFS_COUNT:   rdata_nxt[7:0] = count_r;
            OFS_INTCTL: begin
               rdata_nxt[IEN_BIT]   = irq_en_r;
               rdata_nxt[IFLAG_BIT] = irq_flag_r;
            end
            OFS_OUTCTL: begin
               rdata_nxt[SRC_BIT]   = src_sel_r;
               rdata_nxt[DATA0_BIT] = data_bits_r[0];
               rdata_nxt[DATA1_BIT] = data_bits_r[1];
               rdata_nxt[PULL_BIT]  = pull_r;
            end
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         wait_r  <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler tick and counting decision
   assign rate_mask = PRESCALE_W'((8'h1 << rate) - 8'h1);
   assign tick      = (prescale_r & rate_mask) == rate_mask;

   // Per-mode step request
   always_comb begin
      inc      = 1'b0;
      hw_clear = 1'b0;
      cap_nxt  = cap_r;
      case (mode)
         MODE_EVENT: begin
            // Pin edges step directly, counts through sleep
            inc = en & (edge_sel ? pin_fall : pin_rise);
         end
         MODE_TIMER: begin
            inc = en & tick & ~i_sleep;
         end
         MODE_CAPTURE: begin
            if (!en) begin
               cap_nxt = CAP_WAIT;
            end else begin
               case (cap_r)
                  CAP_WAIT: begin
                     if (edge_sel ? pin_rise : pin_fall) begin
                        cap_nxt = CAP_RUN;
                     end
                  end
                  CAP_RUN: begin
                     if (edge_sel ? pin_fall : pin_rise) begin
                        hw_clear = 1'b1;
                        cap_nxt  = CAP_WAIT;
                     end else begin
                        inc = tick & ~i_sleep;
                     end
                  end
                  default: cap_nxt = CAP_WAIT;
               endcase
            end
         end
         default: begin
            inc     = 1'b0;
            cap_nxt = CAP_WAIT;
         end
      endcase
   end

   assign ovf = inc & (count_r == FULL_COUNT);

   ////////////////////////////////////////////////////////////////////////////
   // Register file, counter, flags and divider next values
   always_comb begin
      control_nxt   = control_r;
      preload_nxt   = preload_r;
      count_nxt     = count_r;
      irq_en_nxt    = irq_en_r;
      irq_flag_nxt  = irq_flag_r;
      src_sel_nxt   = src_sel_r;
      data_bits_nxt = data_bits_r;
      pull_nxt      = pull_r;
      div_state_nxt = div_state_r;
      prescale_nxt  = prescale_r + PRESCALE_W'(1);
      // Counter step and reload
      if (ovf) begin
         count_nxt = preload_r;
      end else if (inc) begin
         count_nxt = count_r + 8'h1;
      end
      // Capture end clears enable, only in capture mode
      if (hw_clear) begin
         control_nxt[EN_BIT] = 1'b0;
      end
      // Sticky request, clear by writing one, set wins
      if (wr_ok && (i_address == OFS_INTCTL)) begin
         irq_en_nxt = i_writedata[IEN_BIT];
         if (i_writedata[IFLAG_BIT]) begin
            irq_flag_nxt = 1'b0;
         end
      end
      if (ovf) begin
         irq_flag_nxt = 1'b1;
      end
      if (ctrl_wr) begin
         control_nxt = i_writedata[7:0] & CONTROL_MASK;
      end
      // Preload lands in the counter when off
      if (pre_wr) begin
         preload_nxt = i_writedata[7:0];
         if (!en) begin
            count_nxt = i_writedata[7:0];
         end
      end
      if (wr_ok && (i_address == OFS_OUTCTL)) begin
         src_sel_nxt      = i_writedata[SRC_BIT];
         data_bits_nxt[0] = i_writedata[DATA0_BIT];
         data_bits_nxt[1] = i_writedata[DATA1_BIT];
         pull_nxt         = i_writedata[PULL_BIT];
      end
      // Divider toggles on the selected overflow
      if (src_sel_r ? i_other_timer_overflow : ovf) begin
         div_state_nxt = ~div_state_r;
      end
   end

   // Registered outputs
   always_comb begin
      irq_out_nxt = irq_flag_nxt & irq_en_nxt;
      wake_nxt    = ovf & i_sleep;
      div_out_nxt = {NUM_DIV_OUT{div_state_nxt}} & data_bits_nxt;
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         control_r   <= CONTROL_RST;
         preload_r   <= 8'h00;
         count_r     <= 8'h00;
         irq_en_r    <= 1'b0;
         irq_flag_r  <= 1'b0;
         src_sel_r   <= 1'b0;
         data_bits_r <= 2'h0;
         pull_r      <= 1'b0;
         div_state_r <= 1'b0;
         prescale_r  <= '0;
         cap_r       <= CAP_WAIT;
         irq_out_r   <= 1'b0;
         wake_r      <= 1'b0;
         div_out_r   <= '0;
      end else begin
         control_r   <= control_nxt;
         preload_r   <= preload_nxt;
         count_r     <= count_nxt;
         irq_en_r    <= irq_en_nxt;
         irq_flag_r  <= irq_flag_nxt;
         src_sel_r   <= src_sel_nxt;
         data_bits_r <= data_bits_nxt;
         pull_r      <= pull_nxt;
         div_state_r <= div_state_nxt;
         prescale_r  <= prescale_nxt;
         cap_r       <= cap_nxt;
         irq_out_r   <= irq_out_nxt;
         wake_r      <= wake_nxt;
         div_out_r   <= div_out_nxt;
      end
   end

   // Output drive
   assign o_readdata                 = rdata_r;
   assign o_waitrequest              = wait_r;
   assign o_timer_irq                = irq_out_r;
   assign o_wakeup                   = wake_r;
   assign o_programmable_divider_out = div_out_r;
   assign o_pin_pullup_en            = pull_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_EVENT_RISE_STEP: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == MODE_EVENT && en && !edge_sel && pin_rise && count_r != FULL_COUNT && !pre_wr)
      |=> count_r == $past(count_r) + 8'h1)
      else $error("event count missed a rising edge");

   AST_EVENT_IGNORE_OTHER: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == MODE_EVENT && edge_sel && !pin_fall && !pre_wr && !ctrl_wr) |=> $stable(count_r))
      else $error("event count moved without a falling edge");

   AST_OVF_RELOAD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (ovf && !pre_wr) |=> (count_r == $past(preload_r)) && irq_flag_r)
      else $error("overflow did not reload or flag");

   AST_IRQ_GATED: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_timer_irq |-> (irq_en_r && irq_flag_r))
      else $error("interrupt out while disabled");

   AST_SLEEP_WAKE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (ovf && i_sleep) |=> o_wakeup)
      else $error("no wake-up on sleep overflow");

   AST_CAPTURE_STOP: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == MODE_CAPTURE && cap_r == CAP_RUN && en && !edge_sel && pin_rise && !ctrl_wr)
      |=> !en ##1 (!en || $past(ctrl_wr)))
      else $error("capture did not clear enable on rising edge");

   AST_CAPTURE_IDLE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == MODE_CAPTURE && cap_r == CAP_WAIT && !pre_wr) |=> $stable(count_r))
      else $error("capture counted before start edge");

   AST_NO_HW_CLEAR: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode != MODE_CAPTURE && en && !ctrl_wr) |=> en)
      else $error("enable cleared without software");

   AST_PRELOAD_OFF: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (pre_wr && !en) |=> count_r == $past(i_writedata[7:0]))
      else $error("preload not copied while off");

   AST_DIV_TOGGLE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (ovf && !src_sel_r) |=> div_state_r != $past(div_state_r))
      else $error("divider did not toggle");

   AST_DIV_GATE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_programmable_divider_out[0] |-> data_bits_r[0])
      else $error("divider output high with data bit clear");

   AST_CAPTURE_STOP_FALL: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == MODE_CAPTURE && cap_r == CAP_RUN && en && edge_sel && pin_fall && !ctrl_wr) |=> !en)
      else $error("capture did not clear enable on falling edge");

   AST_CAPTURE_TICK_ONLY: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == MODE_CAPTURE && cap_r == CAP_RUN && !tick && !pre_wr) |=> $stable(count_r))
      else $error("capture counted between prescaler ticks");

   AST_SINGLE_SHOT: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == MODE_CAPTURE && !en && !ctrl_wr && !pre_wr) |=> (!en && $stable(count_r)))
      else $error("capture restarted without software enable");

   AST_MODE_NONE_HOLD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (mode == MODE_NONE && !pre_wr) |=> $stable(count_r))
      else $error("counter moved with no mode selected");

   AST_DIV_OTHER: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (src_sel_r && i_other_timer_overflow) |=> div_state_r != $past(div_state_r))
      else $error("divider ignored the other timer overflow");

endmodule : event_capture_timer_divider
`default_nettype wire

// ### tb/pin_source.sv
// Pulse source model standing on the external timer input pin
`timescale 1ns/10ps
`default_nettype none
module pin_source (
   input  wire logic i_clk,
   output var  logic o_pin
);
   logic idle_lvl;

   //////////////////////////////////////////////////////////////////////
   // Line starts low; this model only ever drives the pin as a timer input
   initial begin
      idle_lvl = 1'h0;
      o_pin    = 1'h0;
   end

   // Move the rest level, then settle past the synchroniser
   task automatic set_idle(input logic lvl);
      @(posedge i_clk);
      idle_lvl = lvl;
      o_pin <= lvl;
      repeat (6) @(posedge i_clk);
   endtask : set_idle

   // One pulse away from rest; edges kept several clocks apart
   task automatic pulse(input int w);
      @(posedge i_clk);
      o_pin <= ~idle_lvl;
      repeat (w) @(posedge i_clk);
      o_pin <= idle_lvl;
      repeat (6) @(posedge i_clk);
   endtask : pulse
endmodule : pin_source
`default_nettype wire

// ### tb/event_capture_timer_divider_tb.sv
// Self-checking bench for the event capture timer and divider
`timescale 1ns/10ps
`default_nettype none
module event_capture_timer_divider_tb;
   import evt_timer_pkg::*;
   logic        clk, nrst, rd, wr, sleep, oovf;
   logic [4:0]  adr;
   logic [31:0] wdat, rdat;
   logic [3:0]  be;
   logic        wreq, irq, wake, pull, pin;
   logic [1:0]  div;
   logic [31:0] q;
   int          n_fail = 0, tests_run = 0, n_wake = 0;
   logic [4:0]  ofs [6] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14};
   logic [7:0]  rstv [6] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   event_capture_timer_divider DUT (.i_clk(clk), .i_nrst(nrst), .i_address(adr), .i_read(rd), .i_write(wr),
      .i_writedata(wdat), .i_byteenable(be), .o_readdata(rdat), .o_waitrequest(wreq), .i_timer_input_pin(pin),
      .i_other_timer_overflow(oovf), .i_sleep(sleep), .o_timer_irq(irq), .o_wakeup(wake),
      .o_programmable_divider_out(div), .o_pin_pullup_en(pull));
   pin_source SRC (.i_clk(clk), .o_pin(pin));

   //////////////////////////////////////////////////////////////////////
   // Clock and wake pulse counter
   initial clk = 1'h0;
   always #50 clk = ~clk;
   always @(posedge clk) if (wake === 1'h1) n_wake <= n_wake + 1;

   //////////////////////////////////////////////////////////////////////
   // Verdict and comparison helpers
   task automatic print_verdict();
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic rng(input string nm, input logic [7:0] lo, input logic [7:0] hi, input logic [31:0] g);
      tests_run++;
      if ($isunknown(g) || g < lo || g > hi) begin
         n_fail++;
         $display("BAD %s expected %h..%h seen %h", nm, lo, hi, g);
      end
   endtask : rng

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   //////////////////////////////////////////////////////////////////////
   // Avalon access: hold request until waitrequest is sampled low
   task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] b,
                       output logic [31:0] r);
      int t = 0;
      @(posedge clk);
      adr  <= a;
      wdat <= {24'h0, d};
      be   <= b;
      rd   <= ~w;
      wr   <= w;
      do begin
         @(posedge clk);
         t++;
      end while (wreq !== 1'h0 && t < 50);
      r = rdat;
      if (t >= 50) chk("waitrequest", 32'h0, {31'h0, wreq});
      rd <= 1'h0;
      wr <= 1'h0;
   endtask : xfer

   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(1'h1, a, d, 4'h1, r);
   endtask : wr_reg

   task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] e);
      logic [31:0] r;
      xfer(1'h0, a, 8'h00, 4'h0, r);
      chk(nm, {24'h0, e}, r);
   endtask : rd_chk

   task automatic rd_rng(input string nm, input logic [7:0] lo, input logic [7:0] hi);
      logic [31:0] r;
      xfer(1'h0, OFS_COUNT, 8'h00, 4'h0, r);
      rng(nm, lo, hi, r);
   endtask : rd_rng

   task automatic fire();
      @(posedge clk);
      oovf <= 1'h1;
      @(posedge clk);
      oovf <= 1'h0;
      wt(3);
   endtask : fire

   //////////////////////////////////////////////////////////////////////
   // Watchdog against a hung handshake
   initial begin
      wt(20000);
      n_fail++;
      print_verdict();
   end

   //////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      nrst  <= 1'h0;
      rd    <= 1'h0;
      wr    <= 1'h0;
      sleep <= 1'h0;
      oovf  <= 1'h0;
      adr   <= 5'h00;
      wdat  <= 32'h0;
      be    <= 4'h0;
      wt(8);
      nrst <= 1'h1;
      wt(1);
      chk("irq", 32'h0, {31'h0, irq});
      chk("div", 32'h0, {30'h0, div});
      for (int i = 0; i < 6; i++) rd_chk("reset value", ofs[i], rstv[i]);
      wr_reg(OFS_OUTCTL, 8'h0e);
      wt(2);
      chk("pullup", 32'h1, {31'h0, pull});
      wr_reg(OFS_PRELOAD, 8'hfd);
      rd_chk("count load", OFS_COUNT, 8'hfd);
      // Event counting on rising edges, overflow during sleep
      wr_reg(OFS_CONTROL, 8'h50);
      SRC.pulse(4);
      SRC.pulse(4);
      rd_chk("count event", OFS_COUNT, 8'hff);
      sleep <= 1'h1;
      SRC.pulse(4);
      rd_chk("count reload", OFS_COUNT, 8'hfd);
      chk("wake", 32'h1, n_wake);
      chk("irq masked", 32'h0, {31'h0, irq});
      chk("div toggle", 32'h3, {30'h0, div});
      rd_chk("flag", OFS_INTCTL, 8'h02);
      sleep <= 1'h0;
      wr_reg(OFS_INTCTL, 8'h01);
      wt(2);
      chk("irq on", 32'h1, {31'h0, irq});
      wr_reg(OFS_INTCTL, 8'h03);
      wt(2);
      chk("irq clear", 32'h0, {31'h0, irq});
      rd_chk("control kept", OFS_CONTROL, 8'h50);
      // Falling edge counting, then mode none
      wr_reg(OFS_CONTROL, 8'h58);
      SRC.set_idle(1'h1);
      rd_chk("rise ignored", OFS_COUNT, 8'hfd);
      SRC.pulse(4);
      rd_chk("count fall", OFS_COUNT, 8'hfe);
      wr_reg(OFS_CONTROL, 8'h10);
      SRC.pulse(4);
      rd_chk("mode none", OFS_COUNT, 8'hfe);
      // Divider from the other timer, gated by data bits
      wr_reg(OFS_CONTROL, 8'h00);
      wr_reg(OFS_OUTCTL, 8'h0f);
      fire();
      chk("div other", 32'h0, {30'h0, div});
      wr_reg(OFS_OUTCTL, 8'h0b);
      fire();
      chk("div gated", 32'h1, {30'h0, div});
      // Refused writes and unmapped place
      wr_reg(OFS_COUNT, 8'h55);
      rd_chk("count ro", OFS_COUNT, 8'hfe);
      xfer(1'h1, OFS_PRELOAD, 8'h33, 4'h0, q);
      rd_chk("byteenable", OFS_PRELOAD, 8'hfd);
      wr_reg(5'h14, 8'h77);
      rd_chk("unmapped", 5'h14, 8'h00);
      // Capture, start on falling edge, rate 1:1
      wr_reg(OFS_PRELOAD, 8'h00);
      wr_reg(OFS_CONTROL, 8'hd0);
      wt(10);
      rd_chk("capture idle", OFS_COUNT, 8'h00);
      SRC.pulse(20);
      rd_rng("capture low", 8'd19, 8'd21);
      rd_chk("auto clear", OFS_CONTROL, 8'hc0);
      SRC.pulse(20);
      rd_rng("single shot", 8'd19, 8'd21);
      // Capture, start on rising edge, rate 1:2
      wr_reg(OFS_PRELOAD, 8'h00);
      SRC.set_idle(1'h0);
      wr_reg(OFS_CONTROL, 8'hd9);
      SRC.pulse(20);
      rd_rng("capture high", 8'd9, 8'd11);
      rd_chk("auto clear", OFS_CONTROL, 8'hc9);
      // Internal timer mode, counter cleared first while off
      wr_reg(OFS_PRELOAD, 8'h00);
      wr_reg(OFS_CONTROL, 8'h90);
      wt(40);
      wr_reg(OFS_CONTROL, 8'h00);
      rd_rng("timer mode", 8'd38, 8'd46);
      print_verdict();
   end
endmodule : event_capture_timer_divider_tb
`default_nettype wire
